// File: capture_pkg.sv
// Purpose: shared constants and carriers for the input capture array
// Assumes: 32-bit register bus, one 16-byte window per channel
// Notes: source codes index the shared trigger/sync event vector
package capture_pkg;

  localparam int MAX_CH = 16;
  localparam int NUM_TMR = 5;
  localparam int NUM_EXT_EVT = 18;

  // per-channel register offsets, channel window = channel * CH_STRIDE
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [3:0] OFF_CON1 = 4'h0;
  localparam logic [3:0] OFF_CON2 = 4'h4;
  localparam logic [3:0] OFF_BUF = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'hC;

  // capture_timebase_select codes
  localparam logic [2:0] TB_TMR1 = 3'h0;
  localparam logic [2:0] TB_TMR5 = 3'h4;
  localparam logic [2:0] TB_SYSCLK = 3'h7;

  // sync_trigger_source_select codes
  localparam logic [4:0] SRC_NONE = 5'h00;
  localparam logic [4:0] SRC_TMR1 = 5'h01;
  localparam logic [4:0] SRC_ADC1 = 5'h06;
  localparam logic [4:0] SRC_CMP1 = 5'h07;
  localparam logic [4:0] SRC_IC1 = 5'h0A;
  localparam logic [4:0] SRC_OC1 = 5'h13;
  localparam int NUM_SRC_IC = 9;

  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_mode_t;

  // first control register: bits 12:10 time base, 2:1 edge, 0 enable
  typedef struct packed {
    logic [18:0] rsv_hi;
    logic [2:0] capture_timebase_select;
    logic [6:0] rsv_lo;
    edge_mode_t edge_mode;
    logic enable;
  } con1_t;

  // second control register: bit 8 cascade, 7 trigger mode, 6 armed, 4:0 source
  typedef struct packed {
    logic [22:0] rsv_hi;
    logic cascade_pair_enable;
    logic trigger_not_sync_select;
    logic trigger_armed_status;
    logic rsv_lo;
    logic [4:0] sync_trigger_source_select;
  } con2_t;

  localparam con1_t CON1_RST = '0;
  localparam con2_t CON2_RST = '0;
  localparam int STAT_FLAG_BIT = 0;

endpackage : capture_pkg

// File: pin_sync3.sv
// Purpose: bring one capture pin into the clock domain and find its edges
// Assumes: pin is asynchronous to clk
// Notes: a level change counts only once the second and third stages agree
`timescale 1ns/100ps
module pin_sync3 (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  import capture_pkg::*;

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  logic lvl_nxt;

  // s1 feeds s2 only; agreement of s2 and s3 filters metastable settling
  assign lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
  assign rise = lvl_nxt & ~lvl_r;
  assign fall = ~lvl_nxt & lvl_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

endmodule : pin_sync3

// File: capture_array.sv
// Purpose: array of input capture channels with selectable time base, cascade,
//   triggered and synchronized modes, and DMA requests on the first four
// Assumes: APB slave, zero wait states; timers give a tick pulse per count
// Notes: channel window at channel*0x10; out-of-range channel gives pslverr
`timescale 1ns/100ps
module capture_array #(
  parameter int NCH = 16,
  parameter int NDMA = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] cap_pin,
  input wire logic [capture_pkg::NUM_TMR-1:0] tmr_tick,
  input wire logic [capture_pkg::NUM_EXT_EVT-1:0] ext_evt,
  output logic [NCH-1:0] cap_evt,
  output logic [NDMA-1:0] dma_req
);
  import capture_pkg::*;

  con1_t con1_r [MAX_CH];
  con2_t con2_r [MAX_CH];
  logic [15:0] buf_r [MAX_CH];
  logic [15:0] cnt_r [MAX_CH];
  logic [MAX_CH-1:0] flag_r;
  logic [MAX_CH-1:0] evt_r;
  logic [MAX_CH-1:0] hit_w;
  logic [MAX_CH-1:0] tick_w;
  logic [MAX_CH-1:0] wrap_w;
  logic [31:0] src_vec;
  logic [31:0] rdata_nxt;
  logic [31:0] prdata_r;

  // bus decode
  wire [3:0] ch_sel = paddr[7:4];
  wire [3:0] reg_off = {paddr[3:2], 2'b00};
  wire addr_ok = (32'(ch_sel) < NCH);
  wire acc = psel & penable;
  wire wr_ok = acc & pwrite & addr_ok;

  // event vector shared by trigger and sync selects; own capture events feed
  // back registered so that no combinational loop forms between channels
  assign src_vec[SRC_NONE] = 1'b0;
  assign src_vec[SRC_ADC1-1:SRC_TMR1] = ext_evt[4:0];
  assign src_vec[SRC_ADC1] = ext_evt[5];
  assign src_vec[SRC_IC1-1:SRC_CMP1] = ext_evt[8:6];
  assign src_vec[SRC_OC1-1:SRC_IC1] = evt_r[NUM_SRC_IC-1:0];
  assign src_vec[SRC_OC1+8:SRC_OC1] = ext_evt[17:9];
  assign src_vec[31:SRC_OC1+9] = '0;

  genvar i;
  generate
    for (i = 0; i < MAX_CH; i++) begin : g_ch
      if (i < NCH) begin : g_on
        logic rise_w;
        logic fall_w;
        logic [15:0] cnt_nxt;
        pin_sync3 u_sync (
          .clk(clk),
          .sys_rst(sys_rst),
          .pin(cap_pin[i]),
          .rise(rise_w),
          .fall(fall_w)
        );
        wire [2:0] tb = con1_r[i].capture_timebase_select;
        wire tb_tick = (tb == TB_SYSCLK) ? 1'b1 :
          (tb <= TB_TMR5) ? tmr_tick[tb - TB_TMR1] : 1'b0;
        // odd half of a cascaded pair counts on the even half's carry
        wire is_casc_odd = (i % 2 == 1) && con2_r[i].cascade_pair_enable;
        wire is_casc_even = (i % 2 == 0) && (i + 1 < NCH) &&
          con2_r[(i + 1) % MAX_CH].cascade_pair_enable;
        if (i % 2 == 1) begin : g_odd
          assign tick_w[i] = is_casc_odd ? wrap_w[i-1] : tb_tick;
        end else begin : g_even
          assign tick_w[i] = tb_tick;
        end
        assign wrap_w[i] = tick_w[i] & (cnt_r[i] == CNT_MAX);
        edge_mode_t em;
        assign em = con1_r[i].edge_mode;
        wire own_hit = con1_r[i].enable &
          (((em == EDGE_RISE || em == EDGE_BOTH) && rise_w) ||
           ((em == EDGE_FALL || em == EDGE_BOTH) && fall_w));
        // in a pair the odd channel's edge captures both halves together
        assign hit_w[i] = is_casc_even ? hit_w[(i + 1) % MAX_CH] : own_hit;
        wire src_pulse = src_vec[con2_r[i].sync_trigger_source_select];
        wire trig = con2_r[i].trigger_not_sync_select;
        wire armed = con2_r[i].trigger_armed_status;
        wire hold = ~con1_r[i].enable | (trig & ~armed);
        always_comb begin
          cnt_nxt = cnt_r[i];
          if (hold) begin
            cnt_nxt = CNT_ZERO;
          end else if (~trig && src_pulse) begin
            cnt_nxt = CNT_ZERO;
          end else if (tick_w[i]) begin
            cnt_nxt = cnt_r[i] + 16'h0001;
          end
        end
        wire wr_here = wr_ok && (ch_sel == 4'(i));
        wire stat_clr = wr_here && (reg_off == OFF_STAT) && pwdata[STAT_FLAG_BIT];
        always_ff @(posedge clk) begin
          if (sys_rst) begin
            con1_r[i] <= CON1_RST;
            con2_r[i] <= CON2_RST;
            cnt_r[i] <= CNT_ZERO;
            buf_r[i] <= CNT_ZERO;
            flag_r[i] <= 1'b0;
            evt_r[i] <= 1'b0;
          end else begin
            if (wr_here && reg_off == OFF_CON1) begin
              con1_r[i] <= con1_t'(pwdata & 32'h0000_1C07);
            end
            // a trigger arriving in the same cycle as a write still arms if the write sets trigger mode (bit 7)
            if (wr_here && reg_off == OFF_CON2) begin
              con2_r[i] <= con2_t'(pwdata & 32'h0000_01DF);
              if (pwdata[7] && src_pulse) begin
                con2_r[i].trigger_armed_status <= 1'b1;
              end
            end else if (trig && src_pulse) begin
              con2_r[i].trigger_armed_status <= 1'b1;
            end
            cnt_r[i] <= cnt_nxt;
            if (hit_w[i]) begin
              buf_r[i] <= cnt_r[i];
            end
            // set wins over the software clear
            flag_r[i] <= hit_w[i] | (flag_r[i] & ~stat_clr);
            evt_r[i] <= hit_w[i];
          end
        end
      end else begin : g_off
        assign hit_w[i] = 1'b0;
        assign tick_w[i] = 1'b0;
        assign wrap_w[i] = 1'b0;
        always_ff @(posedge clk) begin
          con1_r[i] <= CON1_RST;
          con2_r[i] <= CON2_RST;
          cnt_r[i] <= CNT_ZERO;
          buf_r[i] <= CNT_ZERO;
          flag_r[i] <= 1'b0;
          evt_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign cap_evt = evt_r[NCH-1:0];
  assign dma_req = evt_r[NDMA-1:0];

  // read mux, latched in the setup cycle so data leaves a flip-flop
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (addr_ok) begin
      case (reg_off)
        OFF_CON1: rdata_nxt = 32'(con1_r[ch_sel]);
        OFF_CON2: rdata_nxt = 32'(con2_r[ch_sel]);
        OFF_BUF: rdata_nxt = {16'h0000, buf_r[ch_sel]};
        OFF_STAT: rdata_nxt = {cnt_r[ch_sel], 15'h0000, flag_r[ch_sel]};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= rdata_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = acc & ~addr_ok;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_capture_copy_value: assert property (
    g_ch[0].g_on.own_hit && !g_ch[0].g_on.is_casc_even |=> buf_r[0] == $past(cnt_r[0])
  ) else $error("capture buffer did not take the counter");

  a_flag_set_wins: assert property (
    hit_w[1] |=> flag_r[1] && evt_r[1]
  ) else $error("capture flag not set on capture");

  a_trig_hold_zero: assert property (
    con1_r[3].enable && con2_r[3].trigger_not_sync_select &&
    !con2_r[3].trigger_armed_status ##1 con2_r[3].trigger_not_sync_select
    |-> cnt_r[3] == CNT_ZERO
  ) else $error("triggered channel counted before trigger");

  a_sync_clear_cnt: assert property (
    con1_r[3].enable && !con2_r[3].trigger_not_sync_select && g_ch[3].g_on.src_pulse
    |=> cnt_r[3] == CNT_ZERO
  ) else $error("sync pulse did not clear counter");

  a_sysclk_base_runs: assert property (
    con1_r[3].enable && con1_r[3].capture_timebase_select == TB_SYSCLK &&
    !con2_r[3].trigger_not_sync_select && !g_ch[3].g_on.src_pulse
    |=> cnt_r[3] == $past(cnt_r[3]) + 16'h0001
  ) else $error("system clock time base did not count");

  a_timer_base_still: assert property (
    con1_r[2].enable && con1_r[2].capture_timebase_select == TB_TMR1 &&
    !tmr_tick[0] && !g_ch[2].g_on.src_pulse |=> $stable(cnt_r[2])
  ) else $error("timer time base counted without tick");

  a_cascade_carry: assert property (
    con2_r[5].cascade_pair_enable && con1_r[5].enable && wrap_w[4] &&
    !con2_r[5].trigger_not_sync_select && !g_ch[5].g_on.src_pulse
    |=> cnt_r[5] == $past(cnt_r[5]) + 16'h0001
  ) else $error("odd half missed carry");

  a_dma_follows_hit: assert property (
    hit_w[1] |=> dma_req[1] ##1 (!dma_req[1] || $past(hit_w[1]))
  ) else $error("dma request does not follow capture");

  a_armed_by_src: assert property (
    con2_r[3].trigger_not_sync_select && g_ch[3].g_on.src_pulse &&
    !(g_ch[3].g_on.wr_here && reg_off == OFF_CON2)
    |=> con2_r[3].trigger_armed_status
  ) else $error("trigger pulse did not arm channel");

endmodule : capture_array

// File: evt_model.sv
// Purpose: far-side model of timers, converter, comparators and compare channels
// Assumes: one clock, synchronous active-high reset
// Notes: timer k ticks every k+3 cycles; a rising fire bit gives one event pulse
`timescale 1ns/100ps
module evt_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [17:0] fire,
  output logic [4:0] tmr_tick,
  output logic [17:0] ext_evt
);
  logic [2:0] div_r [5];
  logic [17:0] fire_r;
  // edge detect so a held request still gives a single-cycle pulse
  always_ff @(posedge clk) begin
    fire_r <= sys_rst ? 18'h0_0000 : fire;
    ext_evt <= sys_rst ? 18'h0_0000 : fire & ~fire_r;
    for (int k = 0; k < 5; k++) begin
      div_r[k] <= (sys_rst || div_r[k] == 3'(k + 2)) ? 3'h0 : div_r[k] + 3'h1;
      tmr_tick[k] <= !sys_rst && div_r[k] == 3'(k + 2);
    end
  end
endmodule : evt_model

// File: input_capture_timebase_trigger_sync_tb.sv
// Purpose: self-checking bench for the capture array
// Assumes: zero-wait APB slave, channel window of 0x10 bytes
// Notes: deltas between two captures are compared with the bench's own tick counts
`timescale 1ns/100ps
module input_capture_timebase_trigger_sync_tb;
  import capture_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q, s1, s2, v;
  logic pready, pslverr;
  logic [15:0] cap_pin = 16'h0000;
  logic [15:0] cap_evt, b1, b2;
  logic [17:0] fire = 18'h0_0000;
  logic [17:0] ext_evt;
  logic [4:0] tmr_tick;
  logic [3:0] dma_req;
  logic [31:0] tk [6] = '{default: 32'h0000_0000};
  int num_errors = 0;
  int n_tests = 0;

  always #2.5 clk = ~clk;
  // reference counts: timers 0..4 and the system clock as index 5
  always @(posedge clk) begin
    for (int k = 0; k < 5; k++) tk[k] <= tk[k] + 32'(tmr_tick[k]);
    tk[5] <= tk[5] + 32'h0000_0001;
  end

  capture_array #(.NCH(16), .NDMA(4)) capture_array_i (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_pin(cap_pin),
    .tmr_tick(tmr_tick), .ext_evt(ext_evt), .cap_evt(cap_evt), .dma_req(dma_req));
  evt_model evt_model_i (.clk(clk), .sys_rst(sys_rst), .fire(fire), .tmr_tick(tmr_tick),
    .ext_evt(ext_evt));

  function automatic logic [7:0] ad(input int ch, input logic [3:0] off);
    return 8'(ch * 16) | {4'h0, off};
  endfunction : ad

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    chk(32'(pslverr), 32'h0000_0000);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse(input int b);
    @(posedge clk);
    fire[b] <= 1'b1;
    @(posedge clk);
    fire[b] <= 1'b0;
  endtask : pulse

  // pin held high until the capture event shows, so the input filter cannot drop it, then low 6 cycles
  task automatic cap(input int ch, input int sel, output logic [31:0] s);
    int i;
    @(posedge clk);
    cap_pin[ch] <= 1'b1;
    s = tk[sel];
    for (i = 0; i < 20 && cap_evt[ch] !== 1'b1; i++) @(posedge clk);
    chk(32'(i < 20), 32'h0000_0001);
    if (ch < 4) chk(32'(dma_req[ch]), 32'h0000_0001);
    cap_pin[ch] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : cap

  task automatic capbuf(input int ch, input int sel, output logic [31:0] s,
                        output logic [15:0] b);
    logic [31:0] r;
    cap(ch, sel, s);
    apb(1'b0, ad(ch, OFF_BUF), 32'h0000_0000, r);
    b = r[15:0];
  endtask : capbuf

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, ad(7, OFF_CON2), 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    apb(1'b1, ad(6, OFF_CON2), 32'hFFFF_FFFF, q);
    apb(1'b0, ad(6, OFF_CON2), 32'h0000_0000, q);
    chk(q, 32'h0000_01DF);
    apb(1'b1, ad(1, OFF_CON1), 32'h0000_1C03, q);
    capbuf(1, 5, s1, b1);
    repeat (37) @(posedge clk);
    capbuf(1, 5, s2, b2);
    chk(32'(16'(b2 - b1)), 32'(16'(s2 - s1)));
    apb(1'b0, ad(1, OFF_STAT), 32'h0000_0000, q);
    chk(32'(q[STAT_FLAG_BIT]), 32'h0000_0001);
    apb(1'b1, ad(1, OFF_STAT), 32'h0000_0001, q);
    apb(1'b0, ad(1, OFF_STAT), 32'h0000_0000, q);
    chk(32'(q[STAT_FLAG_BIT]), 32'h0000_0000);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, ad(2, OFF_CON1), {19'h0, 3'(k), 10'h003}, q);
      capbuf(2, k, s1, b1);
      repeat (40) @(posedge clk);
      capbuf(2, k, s2, b2);
      chk(32'(16'(b2 - b1)), 32'(16'(s2 - s1)));
    end
    apb(1'b1, ad(3, OFF_CON1), 32'h0000_1C03, q);
    apb(1'b1, ad(0, OFF_CON1), 32'h0000_1C03, q);
    // code 10 is the capture event of channel 0; 11..18 need other channels
    for (int c = 1; c < 28; c++) begin
      if (c > 10 && c < 19) continue;
      apb(1'b1, ad(3, OFF_CON2), 32'h0000_0080 | 32'(c), q);
      repeat (10) @(posedge clk);
      apb(1'b0, ad(3, OFF_STAT), 32'h0000_0000, q);
      chk(32'(q[31:16]), 32'h0000_0000);
      if (c == 10) cap(0, 5, s1);
      else pulse(c < 10 ? c - 1 : c - 10);
      repeat (3) @(posedge clk);
      apb(1'b0, ad(3, OFF_CON2), 32'h0000_0000, q);
      chk(q, 32'h0000_00C0 | 32'(c));
      apb(1'b0, ad(3, OFF_STAT), 32'h0000_0000, q);
      chk(32'(q[31:16] != 16'h0000), 32'h0000_0001);
    end
    apb(1'b1, ad(3, OFF_CON2), {27'h0, SRC_ADC1}, q);
    repeat (40) @(posedge clk);
    apb(1'b0, ad(3, OFF_STAT), 32'h0000_0000, q);
    chk(32'(q[31:16] > 16'h0010), 32'h0000_0001);
    pulse(5);
    apb(1'b0, ad(3, OFF_STAT), 32'h0000_0000, q);
    chk(32'(q[31:16] < 16'h0010), 32'h0000_0001);
    apb(1'b1, ad(4, OFF_CON1), 32'h0000_1C03, q);
    apb(1'b1, ad(5, OFF_CON1), 32'h0000_1C03, q);
    apb(1'b1, ad(5, OFF_CON2), 32'h0000_0100, q);
    capbuf(5, 5, s1, b1);
    apb(1'b0, ad(4, OFF_BUF), 32'h0000_0000, q);
    v = {b1, q[15:0]};
    // long gap so the low half wraps and the high half must carry
    repeat (70000) @(posedge clk);
    capbuf(5, 5, s2, b2);
    apb(1'b0, ad(4, OFF_BUF), 32'h0000_0000, q);
    chk({b2, q[15:0]} - v, s2 - s1);
    test_done();
  end
endmodule : input_capture_timebase_trigger_sync_tb
